// File: hw/rsr_top.sv
`timescale 1ns/100ps
`include "rsr_map.svh"

module rsr_top (
	// clock, enable, reset
	input wire logic CLK,
	input wire logic CE,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// command bytes from the usb endpoint
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_DATA,
	output logic CMD_READY,
	// reply bytes to the usb endpoint
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_LAST,
	input wire logic RSP_READY,
	// settings applied to the chip
	output logic SERIAL_EN,
	output logic [1:0] SEC_MODE,
	output logic [1:0] CLKOUT_DUTY,
	output logic [2:0] CLKOUT_DIV,
	output logic [1:0] DAC_REF_LEVEL,
	output logic DAC_REF_INT,
	output logic [4:0] DAC_PWRUP_VAL
);

	// =================================================================
	// reply byte builder
	// unlisted positions return zero so the host sees fixed values
	function automatic rsr_pkg::rsr_byte_t reply_byte(
		input rsr_pkg::rsr_idx_t idx,
		input logic [7:0] chip,
		input logic [4:0] clk,
		input logic [7:0] dac,
		input logic [15:0] len
	);
		rsr_pkg::rsr_byte_t b;
		b = `RSR_ZERO_BYTE;
		unique case (idx)
			`RSR_IDX_FIRST: b = `RSR_CMD_GET;
			`RSR_IDX_STAT: b = `RSR_STATUS_OK;
			`RSR_IDX_CLEN: b = len[`RSR_F_LEN_C];
			`RSR_IDX_GLEN: b = len[`RSR_F_LEN_G];
			`RSR_IDX_CHIP: b = chip & `RSR_CHIP_MASK;
			`RSR_IDX_CLK: b[`RSR_F_CLK] = clk;
			`RSR_IDX_DAC: b = dac;
			default: b = `RSR_ZERO_BYTE;
		endcase
		return b;
	endfunction

	// =================================================================
	// state
	rsr_pkg::rsr_state_t state_r;
	rsr_pkg::rsr_state_t state_nxt;
	logic [7:0] chip_cfg_r;
	logic [4:0] clk_cfg_r;
	logic [7:0] dac_cfg_r;
	logic [15:0] len_r;
	logic [5:0] cmd_idx_r;
	logic cmd_bad_r;
	logic cmd_rdy_r;
	logic [5:0] rsp_idx_r;
	logic rsp_valid_r;
	logic [7:0] rsp_data_r;
	logic rsp_last_r;
	logic last_bad_r;
	logic [7:0] rej_cnt_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// =================================================================
	// apb decode
	wire apb_acc = PSEL & PENABLE;
	wire pready_nxt = apb_acc & ~pready_r;
	wire apb_done = apb_acc & pready_r;
	wire hit_chip = (PADDR == `RSR_A_CHIP);
	wire hit_clk = (PADDR == `RSR_A_CLK);
	wire hit_dac = (PADDR == `RSR_A_DAC);
	wire hit_len = (PADDR == `RSR_A_LEN);
	wire hit_stat = (PADDR == `RSR_A_STAT);
	wire addr_ok = hit_chip | hit_clk | hit_dac | hit_len | hit_stat;
	// a write lands only on the completing edge of the access phase
	wire wr_en = apb_done & PWRITE;
	wire wr_chip = wr_en & hit_chip;
	wire wr_clk = wr_en & hit_clk;
	wire wr_dac = wr_en & hit_dac;
	wire wr_len = wr_en & hit_len;
	wire [31:0] rd_mux =
		hit_chip ? {24'h000000, chip_cfg_r} :
		hit_clk ? {27'h0000000, clk_cfg_r} :
		hit_dac ? {24'h000000, dac_cfg_r} :
		hit_len ? {16'h0000, len_r} :
		hit_stat ? {16'h0000, rej_cnt_r, 5'h00, cmd_rdy_r, last_bad_r,
			rsp_valid_r} :
		32'h00000000;
	wire [31:0] prdata_nxt = (pready_nxt & ~PWRITE) ? rd_mux :
		32'h00000000;
	wire pslverr_nxt = pready_nxt & ~addr_ok;

	// =================================================================
	// command intake
	// whole 64-byte frame is checked before any reply starts
	wire cmd_acc = CMD_VALID & cmd_rdy_r;
	wire cmd_first = (cmd_idx_r == `RSR_IDX_FIRST);
	wire cmd_end = cmd_acc & (cmd_idx_r == `RSR_IDX_LAST);
	wire byte_bad = cmd_first ? (CMD_DATA != `RSR_CMD_GET) :
		(CMD_DATA != `RSR_ZERO_BYTE);
	wire bad_nxt = (cmd_bad_r & ~cmd_first) | byte_bad;
	wire cmd_good = cmd_end & ~bad_nxt;
	wire cmd_rej = cmd_end & bad_nxt;

	// =================================================================
	// reply sequencing
	wire rsp_hs = rsp_valid_r & RSP_READY;
	wire rsp_done = rsp_hs & rsp_last_r;
	wire rsp_step = rsp_hs & ~rsp_last_r;
	wire rsp_load = cmd_good | rsp_step;
	wire [5:0] rsp_idx_nxt = cmd_good ? `RSR_IDX_FIRST :
		rsp_step ? rsp_idx_r + 6'h01 : rsp_idx_r;
	// bytes are built from the live registers at the moment they load
	wire [7:0] rsp_byte_nxt = reply_byte(rsp_idx_nxt, chip_cfg_r,
		clk_cfg_r, dac_cfg_r, len_r);
	wire rsp_valid_nxt = cmd_good | (rsp_valid_r & ~rsp_done);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			rsr_pkg::RSR_TAKE_CMD: begin
				if (cmd_good)
					state_nxt = rsr_pkg::RSR_SEND_RSP;
			end
			rsr_pkg::RSR_SEND_RSP: begin
				if (rsp_done)
					state_nxt = rsr_pkg::RSR_TAKE_CMD;
			end
		endcase
	end

	// =================================================================
	// apb response flops
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (CE) begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// =================================================================
	// settings registers, volatile copy that the chip runs from
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			chip_cfg_r <= `RSR_CHIP_RST;
			clk_cfg_r <= `RSR_CLK_RST;
			dac_cfg_r <= `RSR_DAC_RST;
			len_r <= `RSR_LEN_RST;
		end else if (CE) begin
			if (wr_chip)
				chip_cfg_r <= PWDATA[7:0] & `RSR_CHIP_MASK;
			if (wr_clk)
				clk_cfg_r <= PWDATA[`RSR_F_CLK];
			if (wr_dac)
				dac_cfg_r <= PWDATA[7:0];
			if (wr_len)
				len_r <= PWDATA[15:0];
		end
	end

	// =================================================================
	// command intake flops
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cmd_idx_r <= `RSR_IDX_FIRST;
			cmd_bad_r <= 1'b0;
			cmd_rdy_r <= 1'b0;
			last_bad_r <= 1'b0;
			rej_cnt_r <= 8'h00;
		end else if (CE) begin
			if (cmd_acc) begin
				cmd_idx_r <= cmd_idx_r + 6'h01;
				cmd_bad_r <= bad_nxt;
			end
			// no intake while a reply is pending; the host waits
			cmd_rdy_r <= (state_nxt == rsr_pkg::RSR_TAKE_CMD);
			if (cmd_end)
				last_bad_r <= bad_nxt;
			if (cmd_rej)
				rej_cnt_r <= rej_cnt_r + 8'h01;
		end
	end

	// =================================================================
	// reply flops
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_r <= rsr_pkg::RSR_TAKE_CMD;
			rsp_idx_r <= `RSR_IDX_FIRST;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= `RSR_ZERO_BYTE;
			rsp_last_r <= 1'b0;
		end else if (CE) begin
			state_r <= state_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			if (rsp_load) begin
				rsp_idx_r <= rsp_idx_nxt;
				rsp_data_r <= rsp_byte_nxt;
				rsp_last_r <= (rsp_idx_nxt == `RSR_IDX_LAST);
			end else if (rsp_done) begin
				rsp_data_r <= `RSR_ZERO_BYTE;
				rsp_last_r <= 1'b0;
			end
		end
	end

	// =================================================================
	// outputs
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;
	assign CMD_READY = cmd_rdy_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_DATA = rsp_data_r;
	assign RSP_LAST = rsp_last_r;
	assign SERIAL_EN = chip_cfg_r[`RSR_F_SER];
	assign SEC_MODE = chip_cfg_r[`RSR_F_SEC];
	assign CLKOUT_DUTY = clk_cfg_r[`RSR_F_DUTY];
	assign CLKOUT_DIV = clk_cfg_r[`RSR_F_DIV];
	assign DAC_REF_LEVEL = dac_cfg_r[`RSR_F_DREF];
	assign DAC_REF_INT = dac_cfg_r[`RSR_F_DSRC];
	assign DAC_PWRUP_VAL = dac_cfg_r[`RSR_F_DVAL];

	// =================================================================
	// checks
	// ld_q marks the cycle after a reply byte loaded, so $past gives
	// the register values that the byte was built from
	logic ld_q;
	always_ff @(posedge CLK) begin
		if (!RST_N)
			ld_q <= 1'b0;
		else if (CE)
			ld_q <= rsp_load;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	chk_echo_code: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_FIRST |-> RSP_DATA == `RSR_CMD_GET)
		else $error("reply byte 0 is not the command echo");
	chk_success_code: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_STAT |-> RSP_DATA == `RSR_STATUS_OK)
		else $error("reply byte 1 is not the success code");
	chk_reply_start: assert property (
		CE && cmd_good |=> RSP_VALID && rsp_idx_r == `RSR_IDX_FIRST
			&& !CMD_READY)
		else $error("good command did not start a reply");
	chk_chip_len: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CLEN |->
			RSP_DATA == $past(len_r[`RSR_F_LEN_C]))
		else $error("chip area length wrong");
	chk_pin_len: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_GLEN |->
			RSP_DATA == $past(len_r[`RSR_F_LEN_G]))
		else $error("pin area length wrong");
	chk_serial_bit: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CHIP |->
			RSP_DATA[7] == $past(SERIAL_EN))
		else $error("serial enable bit wrong");
	chk_security_field: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CHIP |->
			RSP_DATA[1:0] == $past(SEC_MODE))
		else $error("security field wrong");
	chk_clock_field: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CLK |->
			RSP_DATA[4:0] == $past(clk_cfg_r))
		else $error("clock output field wrong");
	chk_duty_div: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CLK |->
			RSP_DATA[4:3] == $past(CLKOUT_DUTY)
			&& RSP_DATA[2:0] == $past(CLKOUT_DIV))
		else $error("duty or divider position wrong");
	chk_dac_level: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_DAC |->
			RSP_DATA[7:6] == $past(DAC_REF_LEVEL))
		else $error("dac reference level wrong");
	chk_dac_source: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_DAC |->
			RSP_DATA[5] == $past(DAC_REF_INT))
		else $error("dac reference source wrong");
	chk_dac_value: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_DAC |->
			RSP_DATA[4:0] == $past(DAC_PWRUP_VAL))
		else $error("power-up dac value wrong");
	chk_live_settings: assert property (
		CE && wr_dac |=> DAC_PWRUP_VAL == $past(PWDATA[4:0])
			&& DAC_REF_LEVEL == $past(PWDATA[7:6]))
		else $error("dac write not applied at once");
	chk_pad_zero: assert property (
		ld_q && rsp_idx_r > `RSR_IDX_DAC |-> RSP_DATA == `RSR_ZERO_BYTE)
		else $error("unused reply byte not zero");
	chk_pad_bits: assert property (
		ld_q && rsp_idx_r == `RSR_IDX_CHIP |-> RSP_DATA[6:2] == 5'h00)
		else $error("unimplemented bits not zero");
	chk_bad_dropped: assert property (
		CE && cmd_rej |=> !RSP_VALID ##1 CMD_READY || !$past(CE))
		else $error("malformed command answered");
	// intake and reply never overlap, so a new frame cannot race a reply
	chk_intake_hold: assert property (
		RSP_VALID |-> !CMD_READY)
		else $error("command intake open while replying");
	chk_chip_live: assert property (
		CE && wr_chip |=> SERIAL_EN == $past(PWDATA[7])
			&& SEC_MODE == $past(PWDATA[1:0]))
		else $error("chip write not applied at once");
	chk_clk_live: assert property (
		CE && wr_clk |=> CLKOUT_DUTY == $past(PWDATA[4:3])
			&& CLKOUT_DIV == $past(PWDATA[2:0]))
		else $error("clock write not applied at once");

	cov_full_reply: cover property (CE && rsp_done);
	cov_rejected: cover property (CE && cmd_rej);
	cov_write_in_reply: cover property (wr_dac && RSP_VALID);
	cov_stalled_byte: cover property ((RSP_VALID && !RSP_READY) [*3]);
	cov_frozen_reply: cover property (RSP_VALID && !CE);

endmodule

// File: hw/rsr_map.svh
`ifndef RSR_MAP_SVH
`define RSR_MAP_SVH

// =====================================================================
// register byte addresses
`define RSR_A_CHIP 8'h00
`define RSR_A_CLK 8'h04
`define RSR_A_DAC 8'h08
`define RSR_A_LEN 8'h0C
`define RSR_A_STAT 8'h10

// =====================================================================
// packet codes and positions
`define RSR_CMD_GET 8'h61
`define RSR_STATUS_OK 8'h00
`define RSR_ZERO_BYTE 8'h00
`define RSR_IDX_FIRST 6'h00
`define RSR_IDX_LAST 6'h3F
`define RSR_IDX_STAT 6'h01
`define RSR_IDX_CLEN 6'h02
`define RSR_IDX_GLEN 6'h03
`define RSR_IDX_CHIP 6'h04
`define RSR_IDX_CLK 6'h05
`define RSR_IDX_DAC 6'h06

// =====================================================================
// field positions
`define RSR_F_SER 7
`define RSR_F_SEC 1:0
`define RSR_F_DUTY 4:3
`define RSR_F_DIV 2:0
`define RSR_F_CLK 4:0
`define RSR_F_DREF 7:6
`define RSR_F_DSRC 5
`define RSR_F_DVAL 4:0
`define RSR_F_LEN_C 7:0
`define RSR_F_LEN_G 15:8
`define RSR_CHIP_MASK 8'h83

// =====================================================================
// reset values
`define RSR_CHIP_RST 8'h00
`define RSR_CLK_RST 5'h00
`define RSR_DAC_RST 8'h00
`define RSR_LEN_RST 16'h0000
`endif

// File: hw/rsr_pkg.sv
package rsr_pkg;
	// reply engine phase
	typedef enum logic {
		RSR_TAKE_CMD,
		RSR_SEND_RSP
	} rsr_state_t;
	typedef logic [7:0] rsr_byte_t;
	typedef logic [5:0] rsr_idx_t;
endpackage

// File: sim/rsr_host_model.sv
`timescale 1ns/100ps
// =====================================================================
// usb host side: sends command frames, takes reply bytes
module rsr_host_model (
	// clock
	input wire logic clk,
	// command stream
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	input wire logic cmd_ready,
	// reply stream
	input wire logic rsp_valid,
	output logic rsp_ready,
	// bench control
	input wire logic stall
);
	initial begin
		cmd_valid = 1'b0;
		cmd_data = 8'h5A;
		rsp_ready = 1'b0;
	end
	// a stalling host drops ready at random to stretch reply bytes
	always @(posedge clk) begin
		rsp_ready <= (stall && rsp_valid) ? 1'($urandom) : 1'b1;
	end
	// one 64-byte frame; bad_pos 64 keeps it clean
	task automatic send_frame(input int bad_pos);
		logic [7:0] b;
		for (int i = 0; i < 64; i++) begin
			b = (i == 0) ? 8'h61 : 8'h00;
			if (i == bad_pos) begin
				b = b ^ (8'h01 | 8'($urandom));
			end
			cmd_valid <= 1'b1;
			cmd_data <= b;
			do @(posedge clk); while (cmd_ready !== 1'b1);
		end
		cmd_valid <= 1'b0;
		// idle data flips so a stale byte is never mistaken for a good one
		cmd_data <= ~cmd_data;
		// one idle edge, so a following frame never re-drives valid at once
		@(posedge clk);
	endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/100ps
`include "rsr_map.svh"
// =====================================================================
// bench for the settings readback block
module tb_top;
	logic CLK, CE, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, stall;
	logic [7:0] PADDR, CMD_DATA, RSP_DATA;
	logic [31:0] PWDATA, PRDATA;
	logic CMD_VALID, CMD_READY, RSP_VALID, RSP_LAST, RSP_READY;
	logic SERIAL_EN, DAC_REF_INT;
	logic [1:0] SEC_MODE, CLKOUT_DUTY, DAC_REF_LEVEL;
	logic [2:0] CLKOUT_DIV;
	logic [4:0] DAC_PWRUP_VAL;
	logic [32:0] apb_q[$], rsp_q[$];
	logic [31:0] wv[4];
	logic [31:0] msk[4] = '{32'h83, 32'h1F, 32'hFF, 32'hFFFF};
	int fail_count = 0, compares = 0, cyc = 0;
	wire [15:0] set_w = {SERIAL_EN, SEC_MODE, CLKOUT_DUTY, CLKOUT_DIV,
		DAC_REF_LEVEL, DAC_REF_INT, DAC_PWRUP_VAL};

	rsr_top i_dut (.CLK, .CE, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .CMD_VALID, .CMD_DATA,
		.CMD_READY, .RSP_VALID, .RSP_DATA, .RSP_LAST, .RSP_READY,
		.SERIAL_EN, .SEC_MODE, .CLKOUT_DUTY, .CLKOUT_DIV, .DAC_REF_LEVEL,
		.DAC_REF_INT, .DAC_PWRUP_VAL);
	rsr_host_model i_host (.clk(CLK), .cmd_valid(CMD_VALID),
		.cmd_data(CMD_DATA), .cmd_ready(CMD_READY), .rsp_valid(RSP_VALID),
		.rsp_ready(RSP_READY), .stall(stall));

	// =====================================================================
	// clock and shared tasks
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	task automatic chk(input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t exp %h got %h", $time, e, g);
		end
	endtask
	// expectation is noted at setup, before the answer can arrive
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] e);
		apb_q.push_back(e);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic exp_reply(input logic [31:0] v[4]);
		logic [7:0] b;
		for (int i = 0; i < 64; i++) begin
			case (i)
				0: b = 8'h61;
				1: b = 8'h00;
				2: b = v[3][7:0];
				3: b = v[3][15:8];
				4: b = {v[0][7], 5'h00, v[0][1:0]};
				5: b = {3'h0, v[1][4:0]};
				6: b = v[2][7:0];
				default: b = 8'h00;
			endcase
			rsp_q.push_back({24'h0, i == 63, b});
		end
	endtask
	task automatic run_frame(input int bad_pos);
		i_host.send_frame(bad_pos);
		while (rsp_q.size() != 0) @(posedge CLK);
	endtask
	task final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// =====================================================================
	// watchers: a missing note reads as x and so never matches
	always @(posedge CLK) begin
		if (CE && PSEL && PENABLE && PREADY) begin
			chk(apb_q.size() ? apb_q.pop_front() : 'x, {PSLVERR, PRDATA});
		end
		if (RSP_VALID) begin
			chk(33'h0, 33'(CMD_READY));
		end
		if (CE && RSP_VALID && RSP_READY) begin
			chk(rsp_q.size() ? rsp_q.pop_front() : 'x, {RSP_LAST, RSP_DATA});
		end
	end
	// hang guard, well beyond seven frames and the register traffic
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			final_report();
		end
	end

	// =====================================================================
	// main sequence
	initial begin
		CE = 1'b1;
		RST_N = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		stall = 1'b0;
		void'($urandom(32'h4C7BC1D4));
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		chk(33'(set_w), 33'h0);
		for (int a = 0; a < 4; a++) apb(1'b0, 8'(a * 4), 32'h0, 33'h0);
		apb(1'b1, `RSR_A_STAT, 32'hFFFFFFFF, 33'h0);
		apb(1'b0, `RSR_A_STAT, 32'h0, 33'h4);
		apb(1'b0, 8'h14, 32'h0, 33'h100000000);
		apb(1'b1, 8'h20, 32'hFFFFFFFF, 33'h100000000);
		$display("test reset and map done");
		for (int k = 0; k < 4; k++) begin
			for (int a = 0; a < 4; a++) wv[a] = $urandom;
			wv[0][1:0] = 2'(k % 3);
			wv[2][7:6] = 2'(k);
			for (int a = 0; a < 4; a++) apb(1'b1, 8'(a * 4), wv[a], 33'h0);
			for (int a = 0; a < 4; a++) begin
				apb(1'b0, 8'(a * 4), 32'h0, {1'b0, wv[a] & msk[a]});
			end
			chk(33'(set_w), 33'({wv[0][7], wv[0][1:0], wv[1][4:0], wv[2][7:0]}));
			stall <= k[0];
			exp_reply(wv);
			run_frame(64);
			$display("test settings %0d done", k);
		end
		run_frame(17);
		run_frame(0);
		repeat (4) @(posedge CLK);
		apb(1'b0, `RSR_A_STAT, 32'h0, 33'h206);
		exp_reply(wv);
		i_host.send_frame(64);
		// freeze the reply mid-stream; no byte may be lost or sent twice
		repeat (5) @(posedge CLK);
		CE <= 1'b0;
		repeat (3) @(posedge CLK);
		CE <= 1'b1;
		while (rsp_q.size() != 0) @(posedge CLK);
		$display("test bad frames and freeze done");
		final_report();
	end
endmodule
